/* File: rtl/dpvf_ctrl.sv */
// Output path enable, startup settling, volume ramp and filter selection behind an AXI4-Lite slave
module dpvf_ctrl
  import dpvf_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [dpvf_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [dpvf_pkg::DATA_W-1:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // AXI4-Lite read
  input wire logic [dpvf_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [dpvf_pkg::DATA_W-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Mode straps
  input wire logic hw_mode,
  input wire logic strap_filter_pin,
  // Sample path
  input wire logic [31:0] in_sample0,
  input wire logic [31:0] in_sample1,
  output logic [31:0] out_sample0,
  output logic [31:0] out_sample1,
  // Converter controls
  output logic [1:0] out_path_active,
  output logic [15:0] out_gain_now,
  output logic [1:0] out_silence_now,
  // Filter controls
  output logic [1:0] in_filter_now,
  output logic in_highpass_now,
  output logic [2:0] out_filter_now,
  output logic out_highpass_now,
  output logic emphasis_undo_now,
  output logic [1:0] emphasis_undo_set
);
  import dpvf_pkg::*;

  // Software-visible state
  logic [6:0] path_reg;
  logic [DLY_W-1:0] delay_reg;
  logic [31:0] gain_reg;
  logic [15:0] ramp_reg;
  logic [15:0] filt_reg;

  // AXI handshake state
  logic aw_full_reg, w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Byte-lane merge, used by every writable register
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address is mapped when it hits one of the seven words
  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFS_PATH) || (a == OFS_DELAY) || (a == OFS_GAIN) || (a == OFS_COMMIT) ||
           (a == OFS_RAMP) || (a == OFS_FILT) || (a == OFS_STAT);
  endfunction

  // Write channel: address and data accepted in either order, then one response
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire wr_ok = addr_known(aw_addr_reg) && (aw_addr_reg != OFS_STAT);
  assign s_axil_awready = !aw_full_reg && !bvalid_reg;
  assign s_axil_wready = !w_full_reg && !bvalid_reg;
  assign s_axil_bvalid = bvalid_reg;
  assign s_axil_bresp = bresp_reg;
  // Merged words keep old contents in the lanes that the strobe leaves out
  wire [31:0] path_word = lane_merge(32'(path_reg), w_data_reg, w_strb_reg);
  wire [31:0] delay_word = lane_merge(32'(delay_reg), w_data_reg, w_strb_reg);
  wire [31:0] gain_word = lane_merge(gain_reg, w_data_reg, w_strb_reg);
  wire [31:0] ramp_word = lane_merge(32'(ramp_reg), w_data_reg, w_strb_reg);
  wire [31:0] filt_word = lane_merge(32'(filt_reg), w_data_reg, w_strb_reg);
  wire wr_path = do_write && aw_addr_reg == OFS_PATH;
  wire wr_delay = do_write && aw_addr_reg == OFS_DELAY;
  wire wr_gain = do_write && aw_addr_reg == OFS_GAIN;
  wire wr_ramp = do_write && aw_addr_reg == OFS_RAMP;
  wire wr_filt = do_write && aw_addr_reg == OFS_FILT;
  // Commit is a pulse only; nothing is stored, so it always reads back zero
  wire commit = do_write && aw_addr_reg == OFS_COMMIT && w_strb_reg[0] && w_data_reg[0];

  // Holding registers clear when the response is raised; new beats wait until it has been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axil_wdata;
        w_strb_reg <= s_axil_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axil_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register stores; byte enables honoured per lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      path_reg <= PATH_RST;
      delay_reg <= DELAY_RST;
      gain_reg <= '0;
      ramp_reg <= {4'h0, RATE_RST, 4'h0, RATE_RST};
      filt_reg <= FILT_RST;
    end else begin
      if (wr_path) path_reg <= path_word[6:0];
      if (wr_delay) delay_reg <= delay_word[DLY_W-1:0];
      if (wr_gain) gain_reg <= gain_word;
      if (wr_ramp) ramp_reg <= ramp_word[15:0];
      if (wr_filt) filt_reg <= filt_word[15:0];
    end
  end

  // Settling sequencer: off until requested, then a millisecond count, then live
  dpvf_settle_t st_reg, st_next;
  logic [31:0] tick_reg;
  logic [DLY_W-1:0] ms_reg;
  wire ref_off = path_reg[B_REFOFF];
  wire [1:0] ch_en = hw_mode ? 2'b11 : path_reg[B_EN0 +: 2];
  wire glob_en = hw_mode || path_reg[B_GLOBAL];
  wire want = !ref_off && glob_en && (|ch_en);
  wire dly_done = !path_reg[B_DLYON] || (ms_reg >= delay_reg);

  // Shutdown drops back to off so the next enable settles again
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF: if (want) st_next = ST_SETTLE;
      ST_SETTLE: begin
        if (ref_off) st_next = ST_OFF;
        else if (want && dly_done) st_next = ST_LIVE;
      end
      ST_LIVE: if (ref_off) st_next = ST_OFF;
      default: st_next = ST_OFF;
    endcase
  end

  // Counter holds while enables are withdrawn mid-settle rather than restarting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_OFF;
      tick_reg <= '0;
      ms_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (st_reg != ST_SETTLE) begin
        tick_reg <= '0;
        ms_reg <= '0;
      end else if (want && tick_reg == 32'(MS_CYC - 1)) begin
        tick_reg <= '0;
        if (ms_reg != {DLY_W{1'b1}}) ms_reg <= ms_reg + 1'b1;
      end else if (want) begin
        tick_reg <= tick_reg + 1'b1;
      end
    end
  end

  // Channels pass audio only once settled; the port copy is registered
  wire live = (st_reg == ST_LIVE) && want;
  wire [1:0] act_now = live ? ch_en : 2'b00;

  // Pending gain: software field until commit, forced to unity in hardware mode
  logic [GW-1:0] tgt_reg [2];
  logic [GW-1:0] cur_reg [2];
  logic [15:0] rtick_reg [2];
  logic [1:0] mute_tgt_reg;
  wire [RW-1:0] rise_rate = ramp_reg[RW-1:0];
  wire [RW-1:0] fall_rate = ramp_reg[R_FALL +: RW];

  // Ramp step interval from a rate field
  function automatic logic [15:0] rate_span(input logic [RW-1:0] r);
    return 16'(16'h0001 << r);
  endfunction

  // Each channel steps one 0.5 dB count per interval toward its committed target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute_tgt_reg <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        tgt_reg[c] <= ATT_UNITY;
        cur_reg[c] <= ATT_UNITY;
        rtick_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (hw_mode) begin
          tgt_reg[c] <= ATT_UNITY;
          mute_tgt_reg[c] <= 1'b0;
        end else if (commit) begin
          tgt_reg[c] <= gain_reg[c*G_CH1 +: GW];
          mute_tgt_reg[c] <= gain_reg[c*G_CH1 + G_MUTE];
        end
        if (cur_reg[c] == eff_tgt(c)) begin
          rtick_reg[c] <= '0;
        end else if (rtick_reg[c] >= rate_span(cur_reg[c] > eff_tgt(c) ? rise_rate : fall_rate) - 1'b1) begin
          rtick_reg[c] <= '0;
          // Lower code is louder: a falling code is a rising gain
          cur_reg[c] <= cur_reg[c] > eff_tgt(c) ? cur_reg[c] - 1'b1 : cur_reg[c] + 1'b1;
        end else begin
          rtick_reg[c] <= rtick_reg[c] + 1'b1;
        end
      end
    end
  end

  // Mute ramps to full attenuation before the path is silenced
  function automatic logic [GW-1:0] eff_tgt(input int c);
    return mute_tgt_reg[c] ? ATT_MAX : tgt_reg[c];
  endfunction

  // Busy while off target; silence waits for the ramp to reach the floor
  wire [1:0] ramping = {cur_reg[1] != eff_tgt(1), cur_reg[0] != eff_tgt(0)};
  wire [1:0] silent = {mute_tgt_reg[1] && !ramping[1], mute_tgt_reg[0] && !ramping[0]};

  // Sample path: negate on request, zero when inactive or silenced
  function automatic logic [31:0] shape(input logic [31:0] s, input logic flip, input logic pass);
    logic [31:0] v;
    v = flip ? 32'(-s) : s;
    return pass ? v : 32'h0000_0000;
  endfunction

  // Registered so the strap input never reaches a port combinationally
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sample0 <= '0;
      out_sample1 <= '0;
      out_path_active <= 2'b00;
      out_gain_now <= '0;
      out_silence_now <= 2'b00;
    end else begin
      out_sample0 <= shape(in_sample0, path_reg[B_FLIP0], act_now[0] && !silent[0]);
      out_sample1 <= shape(in_sample1, path_reg[B_FLIP0 + 1], act_now[1] && !silent[1]);
      out_path_active <= act_now;
      out_gain_now <= {cur_reg[1], cur_reg[0]};
      out_silence_now <= silent;
    end
  end

  // Filter choice: strap in hardware mode, separate fields in register mode
  wire [3:0] fs = filt_reg[F_FS +: 4];
  wire [1:0] in_sel = hw_mode ? (strap_filter_pin ? HW_IN_SEL1 : 2'h0) : filt_reg[F_IN_SEL +: 2];
  wire [2:0] out_sel = hw_mode ? (strap_filter_pin ? HW_OUT_SEL1 : 3'h0) : filt_reg[F_OUT_SEL +: 3];
  wire [1:0] ro = out_sel[2:1];
  wire slow_ok = (fs >= FS_44K1) && (fs <= FS_192K);
  wire bal_ok = (fs >= FS_88K2) && (fs <= FS_768K);
  wire ro_ok = (ro == RO_FAST) || (ro == RO_SLOW && slow_ok) || (ro == RO_BAL && bal_ok);
  // Unavailable roll-off falls back to fast with the same phase
  wire [2:0] out_eff = ro_ok ? out_sel : {RO_FAST, out_sel[0]};
  wire de_rate_ok = fs <= FS_48K;
  wire de_on = !hw_mode && filt_reg[F_DE_ON] && de_rate_ok;
  wire [1:0] de_set = (fs == FS_32K) ? DE_32K : (filt_reg[F_DE_RATE] ? DE_48K : DE_44K1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_filter_now <= 2'h0;
      in_highpass_now <= 1'b0;
      out_filter_now <= 3'h0;
      out_highpass_now <= 1'b0;
      emphasis_undo_now <= 1'b0;
      emphasis_undo_set <= DE_32K;
    end else begin
      in_filter_now <= in_sel;
      in_highpass_now <= hw_mode || filt_reg[F_IN_HP];
      out_filter_now <= out_eff;
      out_highpass_now <= !hw_mode && filt_reg[F_OUT_HP];
      emphasis_undo_now <= de_on;
      emphasis_undo_set <= de_set;
    end
  end

  // Read channel: one outstanding read, data one cycle after the address
  wire [31:0] stat_word = {cur_reg[1], cur_reg[0], 8'h00, !ro_ok, |ramping, silent,
                           st_reg == ST_SETTLE, live, act_now};
  // Read decode; the commit word and holes read as zero
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axil_araddr)
      OFS_PATH: rd_mux = 32'(path_reg);
      OFS_DELAY: rd_mux = 32'(delay_reg);
      OFS_GAIN: rd_mux = gain_reg;
      OFS_RAMP: rd_mux = 32'(ramp_reg);
      OFS_FILT: rd_mux = 32'(filt_reg);
      OFS_STAT: rd_mux = stat_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign s_axil_arready = !rvalid_reg;
  assign s_axil_rvalid = rvalid_reg;
  assign s_axil_rdata = rdata_reg;
  assign s_axil_rresp = rresp_reg;

  // Read data captured at the address handshake, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= addr_known(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axil_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

/* File: rtl/dpvf_pkg.sv */
// Package of register map, field layout, reset values and timing for the output path control
package dpvf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PATH = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMMIT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RAMP = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FILT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h18;
  // Path control fields
  localparam int B_GLOBAL = 0;
  localparam int B_REFOFF = 1;
  localparam int B_EN0 = 2;
  localparam int B_FLIP0 = 4;
  localparam int B_DLYON = 6;
  localparam logic [6:0] PATH_RST = 7'h40;
  // Delay length in milliseconds, 1 s after reset
  localparam int DLY_W = 16;
  localparam real DELAY_DEFAULT_S = 1.0;
  localparam logic [DLY_W-1:0] DELAY_RST = DLY_W'(int'(DELAY_DEFAULT_S * 1000.0));
  localparam real CLK_HZ = 100.0e6;
  localparam real MS_S = 1.0e-3;
  localparam int MS_CYCLES = int'(MS_S * CLK_HZ);
  // Gain fields: attenuation code, 0.5 dB per count, 0 is 0 dB, 255 is -127.5 dB
  localparam int GW = 8;
  localparam int G_MUTE = 8;
  localparam int G_CH1 = 16;
  localparam logic [GW-1:0] ATT_MAX = 8'hFF;
  localparam logic [GW-1:0] ATT_UNITY = 8'h00;
  // Ramp fields: step interval is 2**rate cycles
  localparam int RW = 4;
  localparam int R_FALL = 8;
  localparam logic [RW-1:0] RATE_RST = 4'h4;
  // Filter fields
  localparam int F_IN_SEL = 0;
  localparam int F_IN_HP = 2;
  localparam int F_OUT_SEL = 4;
  localparam int F_OUT_HP = 7;
  localparam int F_DE_ON = 8;
  localparam int F_DE_RATE = 9;
  localparam int F_FS = 12;
  localparam logic [15:0] FILT_RST = 16'h0000;
  // Sample rate codes
  localparam logic [3:0] FS_32K = 4'h0;
  localparam logic [3:0] FS_44K1 = 4'h1;
  localparam logic [3:0] FS_48K = 4'h2;
  localparam logic [3:0] FS_88K2 = 4'h3;
  localparam logic [3:0] FS_192K = 4'h6;
  localparam logic [3:0] FS_768K = 4'hA;
  // Output roll-off kinds, phase in the low bit of the select
  localparam logic [1:0] RO_FAST = 2'h0;
  localparam logic [1:0] RO_SLOW = 2'h1;
  localparam logic [1:0] RO_BAL = 2'h2;
  // De-emphasis coefficient sets
  localparam logic [1:0] DE_32K = 2'h0;
  localparam logic [1:0] DE_44K1 = 2'h1;
  localparam logic [1:0] DE_48K = 2'h2;
  // Strap choices for hardware mode
  localparam logic [1:0] HW_IN_SEL1 = 2'h2;
  localparam logic [2:0] HW_OUT_SEL1 = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_LIVE} dpvf_settle_t;
endpackage

/* File: sim/dpvf_ctrl_props.sv */
// Port-level checker for the output path control block
module dpvf_ctrl_props
  import dpvf_pkg::*;
#(
  parameter int MS_CYC = 10
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Straps and samples
  input wire logic hw_mode,
  input wire logic strap_filter_pin,
  input wire logic [31:0] out_sample0,
  // Path and gain status
  input wire logic [1:0] out_path_active,
  input wire logic [15:0] out_gain_now,
  input wire logic [1:0] out_silence_now,
  // Filter status
  input wire logic [1:0] in_filter_now,
  input wire logic in_highpass_now,
  input wire logic [2:0] out_filter_now,
  input wire logic emphasis_undo_now
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Conditions held long enough for registered outputs to catch up
  sequence s_idle0; !out_path_active[0] ##1 !out_path_active[0]; endsequence
  sequence s_mute0; out_silence_now[0] ##1 out_silence_now[0]; endsequence
  sequence s_hw_on; hw_mode ##1 hw_mode ##1 hw_mode; endsequence
  sequence s_strap1; (hw_mode && strap_filter_pin) ##1 (hw_mode && strap_filter_pin); endsequence
  sequence s_strap0; (hw_mode && !strap_filter_pin) ##1 (hw_mode && !strap_filter_pin); endsequence

  property p_idle_zero; s_idle0 |-> out_sample0 == 32'h0000_0000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("sample nonzero on idle path");
  property p_mute_zero; s_mute0 |-> out_sample0 == 32'h0000_0000; endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("sample nonzero while silenced");
  property p_mute_max; out_silence_now[0] |-> out_gain_now[7:0] == ATT_MAX; endproperty
  a_mute_max: assert property (p_mute_max) else $error("silenced before full attenuation");
  // Ramp moves a single 0.5 dB count at a time
  property p_gain_step;
    (!hw_mode && !$past(hw_mode) && $changed(out_gain_now[7:0]))
      |-> 8'(out_gain_now[7:0] - $past(out_gain_now[7:0])) inside {8'h01, 8'hFF};
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain jumped more than one count");
  property p_hw_quiet; s_hw_on |-> out_silence_now == 2'b00; endproperty
  a_hw_quiet: assert property (p_hw_quiet) else $error("silence active in hardware mode");
  property p_hw_strap1;
    s_strap1 |-> in_filter_now == HW_IN_SEL1 && in_highpass_now && !emphasis_undo_now;
  endproperty
  a_hw_strap1: assert property (p_hw_strap1) else $error("strap high filter choice wrong");
  property p_hw_strap0; s_strap0 |-> in_filter_now == 2'h0 && out_filter_now == 3'h0; endproperty
  a_hw_strap0: assert property (p_hw_strap0) else $error("strap low filter choice wrong");
  property p_roll_code; out_filter_now[2:1] != 2'h3; endproperty
  a_roll_code: assert property (p_roll_code) else $error("undefined roll-off code");
endmodule

bind dpvf_ctrl dpvf_ctrl_props #(.MS_CYC(MS_CYC)) i_props (.aclk(aclk), .aresetn(aresetn),
  .hw_mode(hw_mode), .strap_filter_pin(strap_filter_pin), .out_sample0(out_sample0),
  .out_path_active(out_path_active), .out_gain_now(out_gain_now), .out_silence_now(out_silence_now),
  .in_filter_now(in_filter_now), .in_highpass_now(in_highpass_now), .out_filter_now(out_filter_now),
  .emphasis_undo_now(emphasis_undo_now));

/* File: sim/dpvf_ctrl_tb.sv */
// Self-checking testbench for the output path control block
module dpvf_ctrl_tb import dpvf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short millisecond keeps settling runs brief
  localparam int MSC = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic hw_mode = 1'b0, strap = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, in0 = 32'h0000_1234, in1 = 32'h0000_0100;
  logic [3:0] wstrb = 4'hF;
  wire logic awready, wready, bvalid, arready, rvalid, inhp, outhp, deon;
  wire logic [1:0] bresp, rresp, act, sil, inf, des;
  wire logic [31:0] rdata, out0, out1;
  wire logic [15:0] gain;
  wire logic [2:0] outf;
  int errors = 0;
  int check_count = 0;

  dpvf_ctrl #(.MS_CYC(MSC)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready), .hw_mode(hw_mode), .strap_filter_pin(strap), .in_sample0(in0), .in_sample1(in1),
    .out_sample0(out0), .out_sample1(out1), .out_path_active(act), .out_gain_now(gain), .out_silence_now(sil),
    .in_filter_now(inf), .in_highpass_now(inhp), .out_filter_now(outf), .out_highpass_now(outhp),
    .emphasis_undo_now(deon), .emphasis_undo_set(des));

  // 100 MHz clock
  always #5 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: address and data offered together, response awaited with bready up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid || !bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (arvalid || !rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // Both channels must go live within the cycle window
  task automatic settle(input logic [31:0] p, input int lo, input int hi);
    int n;
    n = 0;
    wr(OFS_PATH, p, RESP_OKAY);
    while (act !== 2'b11 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk("settle_window", 32'h1, 32'(n >= lo && n <= hi));
  endtask

  // Commit, then time the ramp to the expected code pair
  task automatic ramp(input logic [15:0] e, input int lo, input int hi);
    int n;
    n = 0;
    wr(OFS_COMMIT, 32'h0000_0001, RESP_OKAY);
    while (gain !== e && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk("ramp_window", 32'h1, 32'(n >= lo && n <= hi));
  endtask

  task automatic t_regs();
    rd(OFS_PATH, 32'h0000_0040, RESP_OKAY);
    rd(OFS_DELAY, 32'h0000_03E8, RESP_OKAY);
    rd(OFS_GAIN, 32'h0000_0000, RESP_OKAY);
    rd(OFS_RAMP, 32'h0000_0404, RESP_OKAY);
    rd(OFS_FILT, 32'h0000_0000, RESP_OKAY);
    wr(OFS_COMMIT, 32'h0000_0001, RESP_OKAY);
    rd(OFS_COMMIT, 32'h0000_0000, RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_STAT, 32'h0000_0000, RESP_SLVERR);
    $display("test regs done");
  endtask

  task automatic t_path();
    wr(OFS_DELAY, 32'h0000_0003, RESP_OKAY);
    settle(32'h0000_006D, 3 * MSC - 3, 3 * MSC + 5);
    repeat (2) @(posedge aclk);
    chk("out0_live", in0, out0);
    chk("out1_flip", -in1, out1);
    rd(OFS_STAT, 32'h0000_0007, RESP_OKAY);
    wr(OFS_PATH, 32'h0000_006F, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("ref_off", 32'h0, 32'(act));
    chk("out0_off", 32'h0, out0);
    settle(32'h0000_006D, 3 * MSC - 3, 3 * MSC + 5);
    wr(OFS_PATH, 32'h0000_002F, RESP_OKAY);
    settle(32'h0000_002D, 0, 6);
    $display("test path done");
  endtask

  task automatic t_gain();
    wr(OFS_RAMP, 32'h0000_0201, RESP_OKAY);
    wr(OFS_GAIN, 32'h0000_000A, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("pending", 32'h0, 32'(gain));
    ramp(16'h000A, 34, 46);
    wr(OFS_GAIN, 32'h0000_0000, RESP_OKAY);
    ramp(16'h0000, 16, 26);
    wr(OFS_GAIN, 32'h00FF_0100, RESP_OKAY);
    ramp(16'hFFFF, 1000, 1030);
    repeat (2) @(posedge aclk);
    chk("silence", 32'h1, 32'(sil));
    chk("out0_mute", 32'h0, out0);
    wr(OFS_GAIN, 32'h0000_0000, RESP_OKAY);
    ramp(16'h0000, 500, 520);
    chk("unmute", 32'h0, 32'(sil));
    $display("test gain done");
  endtask

  task automatic t_filt();
    logic [3:0] rt [8] = '{FS_32K, FS_44K1, FS_48K, FS_88K2, FS_768K, FS_192K, FS_768K, FS_32K};
    logic [2:0] os [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h2, 3'h2, 3'h4, 3'h1};
    logic [2:0] oe [8] = '{3'h0, 3'h3, 3'h0, 3'h5, 3'h0, 3'h2, 3'h4, 3'h1};
    logic [1:0] dset [8] = '{DE_32K, DE_44K1, DE_48K, 2'h0, 2'h0, 2'h0, 2'h0, DE_32K};
    logic [7:0] ds = 8'b0010_0100;
    logic [7:0] dn = 8'b1000_0111;
    logic [1:0] ib;
    for (int i = 0; i < 8; i++) begin
      ib = 2'(i);
      wr(OFS_FILT, {16'h0000, rt[i], 2'h0, ds[i], 1'b1, ib[0], os[i], 1'b0, ~ib[0], ib}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("in_filter", 32'(ib), 32'(inf));
      chk("in_hp", 32'(!ib[0]), 32'(inhp));
      chk("out_hp", 32'(ib[0]), 32'(outhp));
      chk("out_filter", 32'(oe[i]), 32'(outf));
      chk("deemph_on", 32'(dn[i]), 32'(deon));
      if (dn[i]) chk("deemph_set", 32'(dset[i]), 32'(des));
    end
    $display("test filt done");
  endtask

  task automatic t_hw();
    int n;
    n = 0;
    // Muted software target in flight, so hardware mode must pull it back
    wr(OFS_GAIN, 32'h0000_0104, RESP_OKAY);
    wr(OFS_COMMIT, 32'h0000_0001, RESP_OKAY);
    wr(OFS_PATH, 32'h0000_0001, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("no_channel", 32'h0, 32'(act));
    @(posedge aclk);
    hw_mode <= 1'b1;
    strap <= 1'b1;
    while ((act !== 2'b11 || gain !== 16'h0000) && n < 50) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
    chk("hw_active", 32'h3, 32'(act));
    chk("hw_gain", 32'h0, 32'(gain));
    chk("hw_in", 32'(HW_IN_SEL1), 32'(inf));
    chk("hw_out", 32'h0, 32'(outf));
    chk("hw_hp", 32'h1, 32'({inhp, outhp, deon} == 3'b100));
    @(posedge aclk);
    strap <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("hw_in0", 32'h0, 32'(inf));
    $display("test hw done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_path();
    t_gain();
    t_filt();
    t_hw();
    conclude();
  end

  // Watchdog, well beyond the longest ramp
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end
endmodule
